// File: verilog/rsi_consts.svh
/*
  Register offsets, field positions and reset values of the receive
  status and receive data interrupt sources.
  Assumes inclusion by bare name from the design files.
*/
// Behaviour
// - Sync or flag found in a sync mode sets exited-search bit 7.
// - Fifteen or sixteen ones on the line set idle-seen bit 6.
// - Async break or HDLC abort sets break/abort bit 5.
// - Armed boundary source: readout of boundary char sets status pending.
// - Boundary tag: address char, carrier loss, frame end, block end.
// - Armed parity source: parity failure or queued abort sets pending.
// - Armed overrun source: readout of overrun char sets pending.
// - Armed status bit stays latched until software writes one to it.
// - Write-one clears exited, HDLC abort, boundary, parity, overrun.
// - Idle and async break clear only after unlatch and line ended.
// - Unarmed source never sets the status pending flag.
// - Arms leave bits 7-5 alone but shape bits 4, 2 and 1.
// - Char arriving with count equal to level sets data pending.
// - Boundary char queued below level sets data pending.
// - High control byte follows last select command 5, 6 or 7.
// - Data pending and in-service clear only by chain control writes.
// - Command/status read that returns unarmed boundary status releases it.
`ifndef RSI_CONSTS_SVH
`define RSI_CONSTS_SVH
`define RSI_OFF_CMD_STATUS 8'h00
`define RSI_OFF_INT_CTRL 8'h04
`define RSI_OFF_CHAIN_CTRL 8'h08
`define RSI_OFF_MODE 8'h0C
`define RSI_STATUS_MASK 8'hF6
`define RSI_POP_MASK 8'h16
`define RSI_BIT_EXITED 7
`define RSI_BIT_IDLE 6
`define RSI_BIT_BREAK 5
`define RSI_BIT_BOUND 4
`define RSI_BIT_PARITY 2
`define RSI_BIT_OVERRUN 1
`define RSI_BIT_QUEUED_ABORT_ENABLE 8
`define RSI_CMD_SEL_FILL 4'h5
`define RSI_CMD_SEL_INT 4'h6
`define RSI_CMD_SEL_DMA 4'h7
`define RSI_RST_LEVEL 8'h00
`define RSI_RST_ARM 8'h00
`endif

// File: verilog/rsi_pkg.sv
/*
  Types shared by the receive interrupt source block.
  Assumes nothing of its surroundings.
*/
package rsi_pkg;
  typedef enum logic [2:0] {
    RSI_MODE_ASYNC, RSI_MODE_NINE_BIT, RSI_MODE_EXT_SYNC, RSI_MODE_HDLC,
    RSI_MODE_ENET, RSI_MODE_BISYNC, RSI_MODE_MONO_SYNC
  } rsi_mode_t;
  typedef enum logic [1:0] {RSI_SEL_FILL, RSI_SEL_INT, RSI_SEL_DMA} rsi_sel_t;
endpackage

// File: verilog/rsi_ifs.sv
/*
  Carriers between the top and its register bus slave and status latch.
  Assumes one clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
interface rsi_regbus_if;
  logic wr_en;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_ok;
  logic rd_en;
  logic [7:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_ok;
  modport slave(output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
    input wr_ok, rd_data, rd_ok);
  modport regs(input wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
    output wr_ok, rd_data, rd_ok);
endinterface

interface rsi_status_if;
  logic [7:0] ev;
  logic [7:0] cond;
  logic [7:0] hold_cond;
  logic [7:0] arm;
  logic [7:0] tag;
  logic [7:0] unlatch;
  logic pop;
  logic csr_read;
  logic [7:0] bits;
  logic [7:0] rise;
  modport owner(output ev, cond, hold_cond, arm, tag, unlatch, pop,
    csr_read, input bits, rise);
  modport latch(input ev, cond, hold_cond, arm, tag, unlatch, pop,
    csr_read, output bits, rise);
endinterface
`default_nettype wire

// File: verilog/rsi_axil_slave.sv
/*
  AXI4-Lite slave front end, one write and one read at a time.
  Assumes the register side decodes address combinationally.
*/
`timescale 1ns/1ps
`default_nettype none
module rsi_axil_slave (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  // AXI4-Lite
  input wire logic [7:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [7:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  // Register side
  rsi_regbus_if.slave rb
);
  assign rb.wr_en = o_awready & i_awvalid & i_wvalid;
  assign rb.wr_addr = i_awaddr;
  assign rb.wr_data = i_wdata;
  assign rb.wr_strb = i_wstrb;
  assign rb.rd_en = o_arready & i_arvalid;
  assign rb.rd_addr = i_araddr;

  // Address and data taken together
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_awready <= 1'b0;
      o_wready <= 1'b0;
    end else begin
      o_awready <= i_awvalid & i_wvalid & ~o_bvalid & ~o_awready;
      o_wready <= i_awvalid & i_wvalid & ~o_bvalid & ~o_awready;
    end
  end

  // Write response
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_bvalid <= 1'b0;
      o_bresp <= 2'h0;
    end else if (rb.wr_en) begin
      o_bvalid <= 1'b1;
      o_bresp <= rb.wr_ok ? 2'h0 : 2'h2;
    end else if (i_bready) begin
      o_bvalid <= 1'b0;
    end
  end

  // Read address and data
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_arready <= 1'b0;
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0;
      o_rresp <= 2'h0;
    end else begin
      o_arready <= i_arvalid & ~o_arready & ~o_rvalid;
      if (rb.rd_en) begin
        o_rvalid <= 1'b1;
        o_rdata <= rb.rd_data;
        o_rresp <= rb.rd_ok ? 2'h0 : 2'h2;
      end else if (i_rready) begin
        o_rvalid <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// File: verilog/rsi_status_latch.sv
/*
  Receive status bits with their latching and unlatching behaviour.
  Assumes event, condition and readout inputs synchronous to the clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "rsi_consts.svh"
module rsi_status_latch #(
  parameter logic [7:0] MASK = `RSI_STATUS_MASK,
  parameter logic [7:0] POP_MASK = `RSI_POP_MASK
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  // Status bits
  rsi_status_if.latch st
);
  genvar i;
  for (i = 0; i < 8; i++) begin : g_bit
    if (!MASK[i]) begin : g_none
      assign st.bits[i] = 1'b0;
      assign st.rise[i] = 1'b0;
    end else if (POP_MASK[i]) begin : g_pop
      logic bit_q;
      logic held_q;
      always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
          bit_q <= 1'b0;
        end else if (st.pop) begin
          bit_q <= st.arm[i] ? ((bit_q & ~st.unlatch[i]) | st.tag[i]) :
            st.tag[i];
        end else if (st.unlatch[i]) begin
          bit_q <= 1'b0;
        end else if (st.csr_read && held_q) begin
          bit_q <= 1'b0;
        end
      end
      always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
          held_q <= 1'b0;
        end else if (st.pop) begin
          held_q <= st.tag[i] & ~st.arm[i];
        end else if (st.unlatch[i] || st.csr_read) begin
          held_q <= 1'b0;
        end
      end
      assign st.bits[i] = bit_q;
      assign st.rise[i] = st.pop & st.tag[i] & st.arm[i];
    end else begin : g_event
      logic bit_q;
      logic unl_q;
      logic set_w;
      assign set_w = st.ev[i] | st.cond[i];
      always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
          bit_q <= 1'b0;
        end else if (set_w) begin
          bit_q <= 1'b1;
        end else if (st.hold_cond[i]) begin
          if (unl_q || st.unlatch[i]) begin
            bit_q <= 1'b0;
          end
        end else if (st.unlatch[i]) begin
          bit_q <= 1'b0;
        end
      end
      always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
          unl_q <= 1'b0;
        end else if (!bit_q) begin
          unl_q <= 1'b0;
        end else if (st.unlatch[i]) begin
          unl_q <= 1'b1;
        end
      end
      assign st.bits[i] = bit_q;
      assign st.rise[i] = set_w & ~bit_q & st.arm[i];
    end
  end
endmodule
`default_nettype wire

// File: verilog/rsi_top.sv
/*
  Receive status and receive data interrupt sources of one channel,
  with their registers over AXI4-Lite.
  Assumes receiver queue events are one-cycle pulses on the core clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "rsi_consts.svh"
module rsi_top #(
  parameter int CW = 8
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  // AXI4-Lite write
  input wire logic [7:0] s_axil_awaddr,
  input wire logic s_axil_awvalid,
  output logic s_axil_awready,
  input wire logic [31:0] s_axil_wdata,
  input wire logic [3:0] s_axil_wstrb,
  input wire logic s_axil_wvalid,
  output logic s_axil_wready,
  output logic [1:0] s_axil_bresp,
  output logic s_axil_bvalid,
  input wire logic s_axil_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axil_araddr,
  input wire logic s_axil_arvalid,
  output logic s_axil_arready,
  output logic [31:0] s_axil_rdata,
  output logic [1:0] s_axil_rresp,
  output logic s_axil_rvalid,
  input wire logic s_axil_rready,
  // Receiver line events
  input wire logic i_sync_found,
  input wire logic i_idle_line,
  input wire logic i_break_line,
  input wire logic i_abort_seen,
  // Queue write side
  input wire logic i_push,
  input wire logic i_push_addr_char,
  input wire logic i_push_carrier_lost,
  input wire logic i_push_frame_last,
  input wire logic i_push_block_term,
  input wire logic [CW-1:0] i_queue_count,
  // Queue readout side
  input wire logic i_pop,
  input wire logic i_pop_boundary_tag,
  input wire logic i_pop_parity_err,
  input wire logic i_pop_abort_after,
  input wire logic i_pop_overrun_tag,
  // Acknowledge from priority chain
  input wire logic i_rs_ack,
  input wire logic i_rd_ack,
  // Flags and levels
  output logic o_rs_pending_flag,
  output logic o_rd_pending_flag,
  output logic o_rs_in_service_flag,
  output logic o_rd_in_service_flag,
  output logic o_push_boundary_tag,
  output logic [CW-1:0] o_dma_level
);
  rsi_regbus_if rb ();
  rsi_status_if st ();

  rsi_axil_slave u_bus (
    .i_core_clk(i_core_clk),
    .i_reset_n(i_reset_n),
    .i_awaddr(s_axil_awaddr),
    .i_awvalid(s_axil_awvalid),
    .o_awready(s_axil_awready),
    .i_wdata(s_axil_wdata),
    .i_wstrb(s_axil_wstrb),
    .i_wvalid(s_axil_wvalid),
    .o_wready(s_axil_wready),
    .o_bresp(s_axil_bresp),
    .o_bvalid(s_axil_bvalid),
    .i_bready(s_axil_bready),
    .i_araddr(s_axil_araddr),
    .i_arvalid(s_axil_arvalid),
    .o_arready(s_axil_arready),
    .o_rdata(s_axil_rdata),
    .o_rresp(s_axil_rresp),
    .o_rvalid(s_axil_rvalid),
    .i_rready(s_axil_rready),
    .rb(rb)
  );

  rsi_status_latch u_latch (
    .i_core_clk(i_core_clk),
    .i_reset_n(i_reset_n),
    .st(st)
  );

  logic [7:0] arm_q;
  logic [CW-1:0] int_level_q;
  logic [CW-1:0] dma_level_q;
  rsi_pkg::rsi_sel_t sel_q;
  rsi_pkg::rsi_mode_t mode_q;
  logic queued_abort_enable_q;
  logic [CW-1:0] hi_byte;
  logic sync_mode;
  logic hdlc;
  logic push_bound;
  logic wr_cs;
  logic wr_ic;
  logic wr_cc;
  logic wr_md;
  logic [3:0] cmd;

  assign wr_cs = rb.wr_en && rb.wr_addr == `RSI_OFF_CMD_STATUS;
  assign wr_ic = rb.wr_en && rb.wr_addr == `RSI_OFF_INT_CTRL;
  assign wr_cc = rb.wr_en && rb.wr_addr == `RSI_OFF_CHAIN_CTRL;
  assign wr_md = rb.wr_en && rb.wr_addr == `RSI_OFF_MODE;
  assign cmd = rb.wr_data[15:12];
  assign sync_mode = mode_q != rsi_pkg::RSI_MODE_ASYNC &&
    mode_q != rsi_pkg::RSI_MODE_NINE_BIT;
  assign hdlc = mode_q == rsi_pkg::RSI_MODE_HDLC;
  assign rb.wr_ok = rb.wr_addr == `RSI_OFF_CMD_STATUS ||
    rb.wr_addr == `RSI_OFF_INT_CTRL || rb.wr_addr == `RSI_OFF_CHAIN_CTRL ||
    rb.wr_addr == `RSI_OFF_MODE;

  assign push_bound =
    (mode_q == rsi_pkg::RSI_MODE_NINE_BIT && i_push_addr_char) ||
    (mode_q == rsi_pkg::RSI_MODE_EXT_SYNC && i_push_carrier_lost) ||
    ((hdlc || mode_q == rsi_pkg::RSI_MODE_ENET) && i_push_frame_last) ||
    (mode_q == rsi_pkg::RSI_MODE_BISYNC && i_push_block_term);

  assign st.ev[`RSI_BIT_EXITED] = i_sync_found & sync_mode;
  assign st.ev[`RSI_BIT_BREAK] = i_abort_seen & hdlc;
  assign st.ev[4:0] = 5'h00;
  assign st.ev[`RSI_BIT_IDLE] = 1'b0;
  assign st.cond[`RSI_BIT_IDLE] = i_idle_line;
  assign st.cond[`RSI_BIT_BREAK] = i_break_line & ~sync_mode;
  assign st.cond[`RSI_BIT_EXITED] = 1'b0;
  assign st.cond[4:0] = 5'h00;
  assign st.hold_cond = {1'b0, 1'b1, ~sync_mode, 5'h00};
  assign st.arm = arm_q & `RSI_STATUS_MASK;
  assign st.tag = {3'h0, i_pop_boundary_tag, 1'b0,
    i_pop_parity_err | (hdlc & queued_abort_enable_q & i_pop_abort_after),
    i_pop_overrun_tag, 1'b0};
  assign st.pop = i_pop;
  assign st.unlatch = (wr_cs && rb.wr_strb[0]) ?
    rb.wr_data[7:0] & `RSI_STATUS_MASK : 8'h00;
  assign st.csr_read = rb.rd_en && rb.rd_addr == `RSI_OFF_CMD_STATUS;

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sel_q <= rsi_pkg::RSI_SEL_FILL;
    end else if (wr_cs && rb.wr_strb[1]) begin
      case (cmd)
        `RSI_CMD_SEL_FILL: sel_q <= rsi_pkg::RSI_SEL_FILL;
        `RSI_CMD_SEL_INT: sel_q <= rsi_pkg::RSI_SEL_INT;
        `RSI_CMD_SEL_DMA: sel_q <= rsi_pkg::RSI_SEL_DMA;
        default: sel_q <= sel_q;
      endcase
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      arm_q <= `RSI_RST_ARM;
    end else if (wr_ic && rb.wr_strb[0]) begin
      arm_q <= rb.wr_data[7:0];
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      int_level_q <= `RSI_RST_LEVEL;
      dma_level_q <= `RSI_RST_LEVEL;
    end else if (wr_ic && rb.wr_strb[1]) begin
      if (sel_q == rsi_pkg::RSI_SEL_INT) begin
        int_level_q <= rb.wr_data[8 +: CW];
      end
      if (sel_q == rsi_pkg::RSI_SEL_DMA) begin
        dma_level_q <= rb.wr_data[8 +: CW];
      end
    end
  end

  // Mode and queued abort
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      mode_q <= rsi_pkg::RSI_MODE_ASYNC;
      queued_abort_enable_q <= 1'b0;
    end else if (wr_md) begin
      if (rb.wr_strb[0]) begin
        mode_q <= rsi_pkg::rsi_mode_t'(rb.wr_data[2:0]);
      end
      if (rb.wr_strb[1]) begin
        queued_abort_enable_q <= rb.wr_data[`RSI_BIT_QUEUED_ABORT_ENABLE];
      end
    end
  end

  // Receive status pending
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rs_pending_flag <= 1'b0;
    end else if (|st.rise) begin
      o_rs_pending_flag <= 1'b1;
    end else if (wr_cc && rb.wr_strb[0] && rb.wr_data[0]) begin
      o_rs_pending_flag <= 1'b0;
    end
  end

  // Receive data pending
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rd_pending_flag <= 1'b0;
    end else if (i_push && (i_queue_count == int_level_q ||
        (push_bound && i_queue_count < int_level_q))) begin
      o_rd_pending_flag <= 1'b1;
    end else if (wr_cc && rb.wr_strb[0] && rb.wr_data[1]) begin
      o_rd_pending_flag <= 1'b0;
    end
  end

  // In-service flags
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rs_in_service_flag <= 1'b0;
      o_rd_in_service_flag <= 1'b0;
    end else begin
      if (i_rs_ack) begin
        o_rs_in_service_flag <= 1'b1;
      end else if (wr_cc && rb.wr_strb[0] && rb.wr_data[2]) begin
        o_rs_in_service_flag <= 1'b0;
      end
      if (i_rd_ack) begin
        o_rd_in_service_flag <= 1'b1;
      end else if (wr_cc && rb.wr_strb[0] && rb.wr_data[3]) begin
        o_rd_in_service_flag <= 1'b0;
      end
    end
  end

  // Tag and level outputs
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_push_boundary_tag <= 1'b0;
      o_dma_level <= `RSI_RST_LEVEL;
    end else begin
      o_push_boundary_tag <= i_push & push_bound;
      o_dma_level <= dma_level_q;
    end
  end

  // Register read decode
  always_comb begin
    case (sel_q)
      rsi_pkg::RSI_SEL_INT: hi_byte = int_level_q;
      rsi_pkg::RSI_SEL_DMA: hi_byte = dma_level_q;
      default: hi_byte = i_queue_count;
    endcase
    rb.rd_ok = 1'b1;
    case (rb.rd_addr)
      `RSI_OFF_CMD_STATUS: rb.rd_data = {24'h0, st.bits[7:1],
        i_queue_count != '0};
      `RSI_OFF_INT_CTRL: rb.rd_data = {16'h0, hi_byte, arm_q};
      `RSI_OFF_CHAIN_CTRL: rb.rd_data = {28'h0, o_rd_in_service_flag,
        o_rs_in_service_flag, o_rd_pending_flag, o_rs_pending_flag};
      `RSI_OFF_MODE: rb.rd_data = {23'h0, queued_abort_enable_q, 5'h0, mode_q};
      default: begin
        rb.rd_data = 32'h0;
        rb.rd_ok = 1'b0;
      end
    endcase
  end

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n);

  sequence s_sel_int_cmd;
    wr_cs && rb.wr_strb[1] && cmd == `RSI_CMD_SEL_INT;
  endsequence

  sequence s_int_lvl_wr;
    sel_q == rsi_pkg::RSI_SEL_INT && wr_ic && rb.wr_strb[1];
  endsequence

  AST_EXITED_SET: assert property (
    i_sync_found && sync_mode |=> st.bits[`RSI_BIT_EXITED])
    else $error("exited bit not set");
  AST_IDLE_HOLD: assert property (
    i_idle_line |=> st.bits[`RSI_BIT_IDLE] [*1] ##0 1)
    else $error("idle bit dropped while line idle");
  AST_BOUND_PEND: assert property (
    i_pop && i_pop_boundary_tag && arm_q[`RSI_BIT_BOUND]
    |=> o_rs_pending_flag) else $error("boundary pending missed");
  AST_OVER_PEND: assert property (
    i_pop && i_pop_overrun_tag && arm_q[`RSI_BIT_OVERRUN]
    |=> o_rs_pending_flag && st.bits[`RSI_BIT_OVERRUN])
    else $error("overrun pending missed");
  AST_W1_CLEAR: assert property (
    st.unlatch[`RSI_BIT_EXITED] && !st.ev[`RSI_BIT_EXITED]
    |=> !st.bits[`RSI_BIT_EXITED]) else $error("exited bit not cleared");
  AST_NO_ARM: assert property (
    arm_q == 8'h00 && !o_rs_pending_flag ##1 arm_q == 8'h00
    |-> !o_rs_pending_flag) else $error("pending set while unarmed");
  AST_RD_LEVEL: assert property (
    i_push && i_queue_count == int_level_q |=> o_rd_pending_flag)
    else $error("data pending missed at level");
  AST_RD_KEEP: assert property (
    o_rd_pending_flag && !(wr_cc && rb.wr_data[1]) |=> o_rd_pending_flag)
    else $error("data pending lost without chain write");
  AST_SEL_CMD: assert property (
    s_sel_int_cmd |=> sel_q == rsi_pkg::RSI_SEL_INT)
    else $error("select command not taken");
  AST_SELECT: assert property (
    s_int_lvl_wr |=> int_level_q == $past(rb.wr_data[8 +: CW]))
    else $error("interrupt level not written after select");
endmodule
`default_nettype wire

// File: verilog/rsi_top_dummy_guard.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// File: test/tb_rsi_top.sv
/*
  Self-checking bench for the receive interrupt source block.
  Assumes the block answers on AXI4-Lite and takes one-cycle event pulses.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_rsi_top;
  logic clk = 1'b0, rst_n = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, qcnt = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, resp;
  logic sync = 1'b0, idle = 1'b0, brk = 1'b0, abrt = 1'b0, push = 1'b0;
  logic paddr = 1'b0, pcar = 1'b0, pfl = 1'b0, pblk = 1'b0, pop = 1'b0;
  logic pbt = 1'b0, ppe = 1'b0, pab = 1'b0, pov = 1'b0, rs_ack = 1'b0;
  logic rd_ack = 1'b0;
  logic rs_p, rd_p, rs_is, rd_is, pbtag;
  logic [7:0] dma_lvl;
  int fail_count = 0, n_checks = 0, bt_cnt = 0;
  int bm[5] = '{1, 2, 3, 4, 5};
  int bq[5] = '{3, 2, 1, 1, 0};

  rsi_top #(.CW(8)) u_dut (
    .i_core_clk(clk), .i_reset_n(rst_n),
    .s_axil_awaddr(awaddr), .s_axil_awvalid(awvalid),
    .s_axil_awready(awready), .s_axil_wdata(wdata), .s_axil_wstrb(wstrb),
    .s_axil_wvalid(wvalid), .s_axil_wready(wready), .s_axil_bresp(bresp),
    .s_axil_bvalid(bvalid), .s_axil_bready(bready),
    .s_axil_araddr(araddr), .s_axil_arvalid(arvalid),
    .s_axil_arready(arready), .s_axil_rdata(rdata), .s_axil_rresp(rresp),
    .s_axil_rvalid(rvalid), .s_axil_rready(rready),
    .i_sync_found(sync), .i_idle_line(idle), .i_break_line(brk),
    .i_abort_seen(abrt), .i_push(push), .i_push_addr_char(paddr),
    .i_push_carrier_lost(pcar), .i_push_frame_last(pfl),
    .i_push_block_term(pblk), .i_queue_count(qcnt), .i_pop(pop),
    .i_pop_boundary_tag(pbt), .i_pop_parity_err(ppe),
    .i_pop_abort_after(pab), .i_pop_overrun_tag(pov),
    .i_rs_ack(rs_ack), .i_rd_ack(rd_ack),
    .o_rs_pending_flag(rs_p), .o_rd_pending_flag(rd_p),
    .o_rs_in_service_flag(rs_is), .o_rd_in_service_flag(rd_is),
    .o_push_boundary_tag(pbtag), .o_dma_level(dma_lvl)
  );

  always #5 clk = ~clk;

  always @(posedge clk) begin
    if (pbtag === 1'b1) bt_cnt++;
  end

  task end_of_test;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v,
                    input logic [3:0] s);
    int i;
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        resp = bresp;
        break;
      end
    end
    bready <= 1'b0;
    if (i == 50) begin
      fail_count++;
      end_of_test();
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    int i;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        v = rdata;
        resp = rresp;
        break;
      end
    end
    rready <= 1'b0;
    if (i == 50) begin
      fail_count++;
      end_of_test();
    end
  endtask

  task st(input logic [7:0] e);
    rd(8'h00, d);
    chk("status", {24'h0, e}, d & 32'hF6);
  endtask

  task ev(input int k);
    @(posedge clk);
    case (k)
      0: sync <= 1'b1;
      1: abrt <= 1'b1;
      2: push <= 1'b1;
      3: pop <= 1'b1;
      4: rs_ack <= 1'b1;
      default: rd_ack <= 1'b1;
    endcase
    @(posedge clk);
    {sync, abrt, push, pop, rs_ack, rd_ack} <= 6'h00;
    repeat (2) @(posedge clk);
  endtask

  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    rd(8'h04, d);
    chk("int ctrl reset", 32'h0, d);
    st(8'h00);
    rd(8'h10, d);
    chk("unmapped data", 32'h0, d);
    chk("unmapped rresp", 32'h2, resp);
    wr(8'h10, 32'hFF, 4'hF);
    chk("unmapped bresp", 32'h2, resp);
    wr(8'h0C, 32'h3, 4'h3);
    ev(0);
    st(8'h80);
    chk("rs pending", 32'h0, rs_p);
    wr(8'h00, 32'h80, 4'h1);
    st(8'h00);
    wr(8'h04, 32'hE0, 4'h1);
    ev(0);
    chk("rs pending", 32'h1, rs_p);
    ev(1);
    st(8'hA0);
    wr(8'h00, 32'hA0, 4'h1);
    st(8'h00);
    wr(8'h08, 32'h1, 4'h1);
    chk("rs pending", 32'h0, rs_p);
    ev(4);
    chk("rs in service", 32'h1, rs_is);
    wr(8'h08, 32'h4, 4'h1);
    chk("rs in service", 32'h0, rs_is);
    wr(8'h0C, 32'h0, 4'h3);
    wr(8'h04, 32'hA0, 4'h1);
    idle <= 1'b1;
    brk <= 1'b1;
    repeat (4) @(posedge clk);
    st(8'h60);
    chk("rs pending", 32'h1, rs_p);
    wr(8'h00, 32'h60, 4'h1);
    st(8'h60);
    idle <= 1'b0;
    brk <= 1'b0;
    wr(8'h00, 32'h60, 4'h1);
    st(8'h00);
    wr(8'h08, 32'h1, 4'h1);
    wr(8'h04, 32'h16, 4'h1);
    {pbt, ppe, pov} <= 3'h7;
    ev(3);
    chk("rs pending", 32'h1, rs_p);
    {pbt, ppe, pov} <= 3'h0;
    ev(3);
    st(8'h16);
    wr(8'h00, 32'h16, 4'h1);
    st(8'h00);
    wr(8'h08, 32'h1, 4'h1);
    wr(8'h04, 32'h00, 4'h1);
    pbt <= 1'b1;
    ev(3);
    pbt <= 1'b0;
    st(8'h10);
    st(8'h00);
    chk("rs pending", 32'h0, rs_p);
    wr(8'h0C, 32'h103, 4'h3);
    wr(8'h04, 32'h04, 4'h1);
    pab <= 1'b1;
    ev(3);
    pab <= 1'b0;
    chk("rs pending", 32'h1, rs_p);
    wr(8'h00, 32'h04, 4'h1);
    wr(8'h08, 32'h1, 4'h1);
    wr(8'h00, 32'h6000, 4'h2);
    wr(8'h04, 32'h0300, 4'h2);
    rd(8'h04, d);
    chk("int level", 32'h0300, d & 32'hFF00);
    wr(8'h00, 32'h7000, 4'h2);
    wr(8'h04, 32'h0500, 4'h2);
    repeat (2) @(posedge clk);
    chk("dma level", 32'h5, dma_lvl);
    qcnt <= 8'h09;
    wr(8'h00, 32'h5000, 4'h2);
    rd(8'h04, d);
    chk("fill level", 32'h0900, d & 32'hFF00);
    qcnt <= 8'h02;
    ev(2);
    chk("rd pending", 32'h0, rd_p);
    qcnt <= 8'h03;
    ev(2);
    chk("rd pending", 32'h1, rd_p);
    ev(3);
    chk("rd pending", 32'h1, rd_p);
    wr(8'h08, 32'h2, 4'h1);
    chk("rd pending", 32'h0, rd_p);
    ev(5);
    ev(3);
    chk("rd in service", 32'h1, rd_is);
    wr(8'h08, 32'h8, 4'h1);
    chk("rd in service", 32'h0, rd_is);
    qcnt <= 8'h01;
    for (int k = 0; k < 5; k++) begin
      wr(8'h0C, bm[k], 4'h3);
      {paddr, pcar, pfl, pblk} <= 4'h1 << bq[k];
      ev(2);
      {paddr, pcar, pfl, pblk} <= 4'h0;
      repeat (2) @(posedge clk);
      chk("rd pending", 32'h1, rd_p);
      chk("boundary tags", k + 1, bt_cnt);
      wr(8'h08, 32'h2, 4'h1);
    end
    end_of_test();
  end
endmodule
`default_nettype wire
